// [sim/dca_dev_model.sv]
// Model of the arbiter device's register bus.
// Assumes address and data hold while chip select is low.
`timescale 1ns/1ps
`include "dca_defines.svh"
module dca_dev_model (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	// Register bus
	input  wire logic       i_cs_n,
	input  wire logic       i_wr_n,
	input  wire logic       i_rd_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	// Timeout request
	input  wire logic       i_fire,
	input  wire logic [2:0] i_who,
	output logic            o_irq
);
	logic [7:0]  mem [256];
	int          wseq [256];
	logic [15:0] cm_log [32];
	logic [7:0]  rv;
	logic [7:0]  last_reg;
	logic [2:0]  who_reg;
	logic        wr_q;
	logic        rd_q;
	int          n_wr;
	int          rx_resets;
	int          busy_cnt;
	////////////////////////////////////////////////////////////////////////////////
	// Read selection
	always_comb begin
		case (i_addr)
			`DEV_CORE_STAT: rv = {7'h0, busy_cnt != 0};
			`DEV_IRQ_STAT: rv = {7'h0, o_irq};
			`DEV_ARB_VIEW: rv = {5'h0, who_reg};
			default: rv = mem[i_addr];
		endcase
	end
	// Released bus shows the inverse of the last value
	assign o_data = (!i_cs_n && !i_rd_n) ? rv : ~last_reg;
	// Bus capture and timeout
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
			wr_q <= 1'b1;
			rd_q <= 1'b1;
			busy_cnt <= 0;
			n_wr <= 0;
			rx_resets <= 0;
			last_reg <= 8'h00;
			who_reg <= 3'h0;
		end else begin
			wr_q <= i_wr_n;
			rd_q <= i_rd_n;
			if (i_fire) begin
				o_irq <= 1'b1;
				who_reg <= i_who;
			end
			if (!i_cs_n && !i_wr_n) begin
				mem[i_addr] <= i_data;
				if (i_addr == `DEV_CM_CMD) busy_cnt <= 2;
			end
			if (!i_cs_n && !i_wr_n && wr_q) begin
				n_wr <= n_wr + 1;
				wseq[i_addr] <= n_wr;
				if (i_addr == `DEV_CM_CMD) cm_log[mem[`DEV_CM_ADDR][4:0]] <= {i_data, mem[`DEV_CM_DATA]};
				if (i_addr == `DEV_HDLC_CMD && i_data == `HDLC_RX_RESET) begin
					o_irq <= 1'b0;
					rx_resets <= rx_resets + 1;
				end
			end
			if (!i_cs_n && !i_rd_n) begin
				last_reg <= rv;
				if (rd_q && i_addr == `DEV_CORE_STAT && busy_cnt != 0) busy_cnt <= busy_cnt - 1;
			end
		end
	end
endmodule

// [sim/dca_host_monitor.sv]
// Concurrent checks on the host's APB and device bus ports.
// Assumes it is bound to dca_host and sees only its ports.
`timescale 1ns/1ps
`include "dca_defines.svh"
module dca_host_monitor (
	// Clock and reset
	input wire logic        i_clock,
	input wire logic        i_reset_n,
	// APB
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// Device bus
	input wire logic        o_dev_cs_n,
	input wire logic        o_dev_wr_n,
	input wire logic        o_dev_rd_n,
	input wire logic [7:0]  o_dev_addr,
	input wire logic [7:0]  o_dev_data_out,
	input wire logic        o_dev_data_oe
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////////////////////////////////////////////////////
	// Mapped offsets
	wire logic mapped;
	wire logic wr_on;
	assign mapped = i_paddr inside {`APB_CTRL, `APB_SUB_CFG, `APB_BCAST, `APB_EXCL, `APB_STATUS};
	assign wr_on = !o_dev_wr_n && !o_dev_cs_n;
	////////////////////////////////////////////////////////////////////////////////
	// APB answers
	a_zero_wait: assert property (i_psel |-> o_pready) else $error("pready low");
	a_unmapped_err: assert property (i_psel && i_penable && !mapped |-> o_pslverr) else $error("no slverr");
	// Device bus framing
	a_write_strobe: assert property ($fell(o_dev_wr_n) |-> (wr_on && o_dev_data_oe)[*4]
		##1 (o_dev_wr_n && !o_dev_cs_n) ##1 o_dev_cs_n) else $error("bad write cycle");
	a_read_strobe: assert property ($fell(o_dev_rd_n) |-> (!o_dev_rd_n && !o_dev_cs_n && !o_dev_data_oe)[*4]
		##1 (o_dev_rd_n && !o_dev_cs_n) ##1 o_dev_cs_n) else $error("bad read cycle");
	a_setup_first: assert property ($fell(o_dev_cs_n) |-> o_dev_wr_n && o_dev_rd_n
		##1 !(o_dev_wr_n && o_dev_rd_n)) else $error("no setup cycle");
	a_addr_held: assert property (!o_dev_cs_n && !$past(o_dev_cs_n) |->
		$stable(o_dev_addr) && $stable(o_dev_data_out)) else $error("address moved");
	// Device values
	a_clock_mode: assert property (wr_on && o_dev_addr == `DEV_HDLC_CLK |->
		o_dev_data_out == `HDLC_CLK_MODE3) else $error("clock mode wrong");
	a_frame_bits: assert property (wr_on && o_dev_addr == `DEV_PORT_BITS |->
		o_dev_data_out == `PORT_BITS_256) else $error("frame bits wrong");
	a_cm_codes: assert property (wr_on && o_dev_addr == `DEV_CM_CMD |->
		o_dev_data_out inside {8'h7A, 8'h7B}) else $error("cm code wrong");
	a_rx_reset: assert property (wr_on && o_dev_addr == `DEV_HDLC_CMD |->
		o_dev_data_out == `HDLC_RX_RESET) else $error("bad controller command");
	// Scenarios
	c_write: cover property ($fell(o_dev_wr_n));
	c_read: cover property ($fell(o_dev_rd_n));
	c_refused: cover property (o_pslverr);
endmodule

// [sim/testbench.sv]
// Self-checking bench for the D-channel arbiter host controller.
// Assumes the device model answers the register bus and raises timeouts on request.
`timescale 1ns/1ps
`include "dca_defines.svh"
module testbench;
	logic        i_clock, i_reset_n, psel, penable, pwrite, fire, pready, pslverr, err;
	logic        cs_n, wr_n, rd_n, oe, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  dev_addr, dev_out, dev_in;
	logic [2:0]  who;
	int          n_errors, checks_done;
	////////////////////////////////////////////////////////////////////////////////
	// Clock, design and device model
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	dca_host dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_dev_cs_n(cs_n), .o_dev_wr_n(wr_n), .o_dev_rd_n(rd_n), .o_dev_addr(dev_addr),
		.o_dev_data_out(dev_out), .o_dev_data_oe(oe), .i_dev_data_in(dev_in), .i_arbiter_timeout_irq(irq));
	dca_dev_model dev (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
		.i_addr(dev_addr), .i_data(dev_out), .o_data(dev_in), .i_fire(fire), .i_who(who), .o_irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and hang report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic hang(input string msg);
		n_errors++;
		$display("mismatch at %0t: %s timed out", $time, msg);
		end_of_test();
	endtask
	// One APB transfer; result left in rd and err
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) hang("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll status until not busy and running
	task automatic wait_idle();
		int n = 0;
		do begin
			apb(1'b0, `APB_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 2000);
		if (n >= 2000) hang("idle");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset values and refused words
	task automatic t_regs();
		apb(1'b0, `APB_STATUS, 32'h0);
		chk(rd, 32'h0, "reset status");
		apb(1'b1, `APB_EXCL, 32'h0000_005A);
		apb(1'b0, `APB_EXCL, 32'h0);
		chk(rd[7:0], 8'h5A, "excl readback");
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		chk(err, 1'b1, "unmapped write");
		apb(1'b0, 12'h020, 32'h0);
		chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
		apb(1'b1, `APB_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, `APB_STATUS, 32'h0);
		chk(rd, 32'h0, "status ro");
	endtask
	// Configure, start, compare device
	task automatic t_setup(input logic bc, input logic [7:0] mask, input logic [2:0] xs,
		input logic [3:0] ci, input logic [7:0] grp, input logic [7:0] ex);
		apb(1'b1, `APB_SUB_CFG, {12'h0, ci, 5'h0, xs, mask});
		apb(1'b1, `APB_BCAST, {24'h0, grp});
		apb(1'b1, `APB_EXCL, {24'h0, ex});
		apb(1'b1, `APB_CTRL, {30'h0, bc, 1'b1});
		wait_idle();
		chk(rd[23:16], mask, "live mask");
		chk(dev.mem[`DEV_HDLC_CLK], `HDLC_CLK_MODE3, "clock mode");
		chk(dev.mem[`DEV_HDLC_FILL], `HDLC_FILL_ONES, "fill");
		chk(dev.mem[`DEV_HDLC_MODE], `HDLC_MODE_VAL, "hdlc mode");
		chk({dev.mem[`DEV_PORT_MODE], dev.mem[`DEV_PORT_BITS]}, {`PORT_MODE_0, `PORT_BITS_256}, "port");
		for (int s = 0; s < `SUB_COUNT; s++) begin
			chk(dev.cm_log[4*s+2], {`CM_CMD_HI, `CM_CODE_EVEN, 2'b11, ci, 2'b11}, "even slot");
			chk(dev.cm_log[4*s+3], {`CM_CMD_HI, `CM_CODE_ODD, `CM_DONT_CARE}, "odd slot");
		end
		chk(dev.mem[`DEV_DCH_EN], mask, "enable mask");
		chk(dev.mem[`DEV_XSEL], {bc, 4'h0, xs}, "selection");
		chk({dev.mem[`DEV_BCAST_GRP], dev.mem[`DEV_EXCL]}, {grp, ex}, "group, excl");
		chk(dev.wseq[`DEV_HDLC_FILL] < dev.wseq[`DEV_DCH_EN], 1'b1, "core first");
	endtask
	// Third timeout disables the offender
	task automatic t_timeout();
		for (int k = 1; k <= 3; k++) begin
			who <= 3'h5;
			fire <= 1'b1;
			@(posedge i_clock);
			fire <= 1'b0;
			for (int n = 0; n < 500 && dev.rx_resets < k; n++) @(posedge i_clock);
			if (dev.rx_resets < k) hang("rx reset");
			chk(dev.rx_resets, k, "rx reset");
			wait_idle();
			chk(rd[10:8], 3'h5, "offender");
			chk(rd[31:24], k, "count");
		end
		chk(dev.mem[`DEV_DCH_EN], 8'h85, "disabled");
		chk(rd[23:16], 8'h85, "live mask");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		{psel, penable, pwrite, paddr, pwdata, fire, who} = '0;
		n_errors = 0;
		checks_done = 0;
		i_reset_n = 1'b0;
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_regs();
		t_setup(1'b0, 8'h3C, 3'h3, 4'h0, 8'h00, 8'h20);
		t_setup(1'b1, 8'hA5, 3'h0, 4'h9, 8'hC3, 8'h07);
		t_timeout();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge i_clock);
		hang("run");
	end
endmodule

bind dca_host dca_host_monitor mon (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_dev_cs_n(o_dev_cs_n), .o_dev_wr_n(o_dev_wr_n), .o_dev_rd_n(o_dev_rd_n), .o_dev_addr(o_dev_addr),
	.o_dev_data_out(o_dev_data_out), .o_dev_data_oe(o_dev_data_oe));

// [src/dca_defines.svh]
// Constants for the arbiter host: APB map, device map, codes, timing.
// Assumes the board decodes device addresses as listed.
`ifndef DCA_DEFINES_SVH
`define DCA_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and device bus timing
`define CLK_PERIOD_NS    25
`define DEV_STROBE_NS    100
`define DEV_STROBE_CYC   ((`DEV_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

////////////////////////////////////////////////////////////////////////////////
// APB register offsets of this controller
`define APB_CTRL         12'h000
`define APB_SUB_CFG      12'h004
`define APB_BCAST        12'h008
`define APB_EXCL         12'h00C
`define APB_STATUS       12'h010

// Field positions
`define CTRL_START_BIT   0
`define CTRL_BCAST_BIT   1
`define SUB_XSEL_LSB     8
`define SUB_CI_LSB       16

////////////////////////////////////////////////////////////////////////////////
// Device register addresses
`define DEV_HDLC_MODE    8'h00
`define DEV_HDLC_CLK     8'h01
`define DEV_HDLC_FILL    8'h02
`define DEV_HDLC_CMD     8'h03
`define DEV_PORT_MODE    8'h10
`define DEV_PORT_BITS    8'h11
`define DEV_CM_DATA      8'h20
`define DEV_CM_ADDR      8'h21
`define DEV_CM_CMD       8'h22
`define DEV_CORE_STAT    8'h23
`define DEV_DCH_EN       8'h30
`define DEV_XSEL         8'h31
`define DEV_BCAST_GRP    8'h32
`define DEV_EXCL         8'h33
`define DEV_IRQ_STAT     8'h34
`define DEV_ARB_VIEW     8'h35

////////////////////////////////////////////////////////////////////////////////
// Device register values and codes
`define HDLC_MODE_VAL    8'h08
`define HDLC_CLK_MODE3   8'h03
`define HDLC_FILL_ONES   8'h01
`define HDLC_RX_RESET    8'h40
`define PORT_MODE_0      8'h00
`define PORT_BITS_256    8'hFF
`define CM_CMD_HI        4'h7
`define CM_CODE_EVEN     4'hA
`define CM_CODE_ODD      4'hB
`define CM_DONT_CARE     8'hFF
`define CM_BUSY_BIT      0
`define IRQ_TIMEOUT_BIT  0
`define XSEL_BCAST_BIT   7

////////////////////////////////////////////////////////////////////////////////
// Sequencer layout
`define SUB_COUNT        8
`define STEP_SUB_BASE    7'h05
`define STEP_TAIL_BASE   7'h45
`define STEP_LAST        7'h48
`define ERR_LIMIT        2'h3

`endif

// [src/dca_host.sv]
// Host controller: sets up the arbiter device, services its timeout.
// Assumes APB from software and an 8-bit device register bus.
//
// How it works
// - HDLC controller set clock mode 3, ones fill
// - HDLC controller kept out of automatic mode
// - Serial port mode 0, 256 bits per frame
// - Downstream codes 1010 even, 1011 odd slot
// - Even slot data: 11, C/I code, 11
// - Single destination or broadcast flag written to transmit selection
// - Subscribers send all ones as idle fill
// - Blocked code written, subscriber enabled in mask
// - On timeout reset receiver; disable frequent offenders
// - Core and HDLC set up before arbiter
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "dca_defines.svh"
module dca_host (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Device register bus
	output logic             o_dev_cs_n,
	output logic             o_dev_wr_n,
	output logic             o_dev_rd_n,
	output logic      [7:0]  o_dev_addr,
	output logic      [7:0]  o_dev_data_out,
	output logic             o_dev_data_oe,
	input  wire logic [7:0]  i_dev_data_in,
	// Device interrupt
	input  wire logic        i_arbiter_timeout_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	dca_pkg::ctl_state_t state_reg;
	dca_pkg::op_t        cur_op;
	logic [6:0]          step_reg;
	logic [7:0]          cfg_mask_reg;
	logic [2:0]          cfg_xsel_reg;
	logic [3:0]          cfg_ci_reg;
	logic                cfg_bcast_reg;
	logic [7:0]          cfg_bcg_reg;
	logic [7:0]          cfg_excl_reg;
	logic [7:0]          live_mask_reg;
	logic [2:0]          who_reg;
	logic                hit_reg;
	logic [7:0]          tmo_cnt_reg;
	logic [1:0]          err_cnt_reg [`SUB_COUNT];
	logic                acc_go_reg;
	logic                acc_write_reg;
	logic [7:0]          acc_addr_reg;
	logic [7:0]          acc_wdata_reg;
	logic                acc_done;
	logic [7:0]          acc_rdata;
	logic                irq_sync;
	logic [31:0]         prdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Step table: HDLC, port, control memory, arbiter
	function automatic dca_pkg::op_t step_op(
		input logic [6:0] idx,
		input logic [7:0] mask,
		input logic [2:0] xsel,
		input logic       bcast,
		input logic [7:0] broadcast_group_select,
		input logic [7:0] excl,
		input logic [3:0] ci
	);
		dca_pkg::op_t op;
		logic [6:0]   rel;
		logic [2:0]   sub;
		logic [7:0]   slot_even;
		logic [7:0]   slot_odd;
		op        = '{kind: dca_pkg::OP_WRITE, addr: 8'h00, data: 8'h00};
		rel       = idx - `STEP_SUB_BASE;
		sub       = rel[5:3];
		slot_even = {3'b000, sub, 2'b10};
		slot_odd  = {3'b000, sub, 2'b11};
		if (idx < `STEP_SUB_BASE) begin
			unique case (idx[2:0])
				3'h0: op = '{dca_pkg::OP_WRITE, `DEV_HDLC_MODE, `HDLC_MODE_VAL};
				3'h1: op = '{dca_pkg::OP_WRITE, `DEV_HDLC_CLK, `HDLC_CLK_MODE3};
				3'h2: op = '{dca_pkg::OP_WRITE, `DEV_HDLC_FILL, `HDLC_FILL_ONES};
				3'h3: op = '{dca_pkg::OP_WRITE, `DEV_PORT_MODE, `PORT_MODE_0};
				default: op = '{dca_pkg::OP_WRITE, `DEV_PORT_BITS, `PORT_BITS_256};
			endcase
		end else if (idx < `STEP_TAIL_BASE) begin
			unique case (rel[2:0])
				3'h0: op = '{dca_pkg::OP_WRITE, `DEV_CM_DATA, {2'b11, ci, 2'b11}};
				3'h1: op = '{dca_pkg::OP_WRITE, `DEV_CM_ADDR, slot_even};
				3'h2: op = '{dca_pkg::OP_WRITE, `DEV_CM_CMD, {`CM_CMD_HI, `CM_CODE_EVEN}};
				3'h3: op = '{dca_pkg::OP_POLL, `DEV_CORE_STAT, 8'h00};
				3'h4: op = '{dca_pkg::OP_WRITE, `DEV_CM_DATA, `CM_DONT_CARE};
				3'h5: op = '{dca_pkg::OP_WRITE, `DEV_CM_ADDR, slot_odd};
				3'h6: op = '{dca_pkg::OP_WRITE, `DEV_CM_CMD, {`CM_CMD_HI, `CM_CODE_ODD}};
				default: op = '{dca_pkg::OP_POLL, `DEV_CORE_STAT, 8'h00};
			endcase
		end else begin
			unique case (idx[1:0])
				2'h1: op = '{dca_pkg::OP_WRITE, `DEV_DCH_EN, mask};
				2'h2: op = '{dca_pkg::OP_WRITE, `DEV_XSEL, {bcast, 4'h0, xsel}};
				2'h3: op = '{dca_pkg::OP_WRITE, `DEV_BCAST_GRP, broadcast_group_select};
				default: op = '{dca_pkg::OP_WRITE, `DEV_EXCL, excl};
			endcase
		end
		return op;
	endfunction

	assign cur_op = step_op(step_reg, live_mask_reg, cfg_xsel_reg, cfg_bcast_reg,
		cfg_bcg_reg, cfg_excl_reg, cfg_ci_reg);

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire apb_setup  = i_psel & ~i_penable;
	wire apb_write  = i_psel & i_penable & i_pwrite;
	wire hit_ctrl   = (i_paddr == `APB_CTRL);
	wire hit_sub    = (i_paddr == `APB_SUB_CFG);
	wire hit_bcast  = (i_paddr == `APB_BCAST);
	wire hit_excl   = (i_paddr == `APB_EXCL);
	wire hit_status = (i_paddr == `APB_STATUS);
	wire mapped     = hit_ctrl | hit_sub | hit_bcast | hit_excl | hit_status;
	wire start_cmd  = apb_write & hit_ctrl & i_pwdata[`CTRL_START_BIT];
	wire busy       = ~(state_reg == dca_pkg::S_IDLE) & ~(state_reg == dca_pkg::S_RUN);
	wire running    = ~(state_reg == dca_pkg::S_IDLE) & ~(state_reg == dca_pkg::S_ISSUE)
		& ~(state_reg == dca_pkg::S_WAIT);

	// Read mux, latched in the setup cycle
	wire [31:0] rd_mux =
		hit_ctrl   ? {30'h0, cfg_bcast_reg, 1'b0} :
		hit_sub    ? {12'h000, cfg_ci_reg, 5'h00, cfg_xsel_reg, cfg_mask_reg} :
		hit_bcast  ? {24'h00_0000, cfg_bcg_reg} :
		hit_excl   ? {24'h00_0000, cfg_excl_reg} :
		hit_status ? {tmo_cnt_reg, live_mask_reg, 5'h00, who_reg, 6'h00, running, busy} :
		32'h0000_0000;

	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;
	assign o_prdata  = prdata_reg;

	// Software configuration registers
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prdata_reg    <= 32'h0000_0000;
			cfg_bcast_reg <= 1'b0;
			cfg_mask_reg  <= 8'h00;
			cfg_xsel_reg  <= 3'h0;
			cfg_ci_reg    <= 4'h0;
			cfg_bcg_reg   <= 8'h00;
			cfg_excl_reg  <= 8'h00;
		end else begin
			if (apb_setup)
				prdata_reg <= rd_mux;
			if (apb_write & hit_ctrl)
				cfg_bcast_reg <= i_pwdata[`CTRL_BCAST_BIT];
			if (apb_write & hit_sub) begin
				cfg_mask_reg <= i_pwdata[7:0];
				cfg_xsel_reg <= i_pwdata[`SUB_XSEL_LSB +: 3];
				cfg_ci_reg   <= i_pwdata[`SUB_CI_LSB +: 4];
			end
			if (apb_write & hit_bcast)
				cfg_bcg_reg <= i_pwdata[7:0];
			if (apb_write & hit_excl)
				cfg_excl_reg <= i_pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pin enters through two flip-flops
	sync2 #(.W(1)) u_irq_sync (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_async   (i_arbiter_timeout_irq),
		.o_sync    (irq_sync)
	);

	// Device bus access engine
	dev_access u_access (
		.i_clock        (i_clock),
		.i_reset_n      (i_reset_n),
		.i_go           (acc_go_reg),
		.i_write        (acc_write_reg),
		.i_addr         (acc_addr_reg),
		.i_wdata        (acc_wdata_reg),
		.o_done         (acc_done),
		.o_rdata        (acc_rdata),
		.o_dev_cs_n     (o_dev_cs_n),
		.o_dev_wr_n     (o_dev_wr_n),
		.o_dev_rd_n     (o_dev_rd_n),
		.o_dev_addr     (o_dev_addr),
		.o_dev_data_out (o_dev_data_out),
		.o_dev_data_oe  (o_dev_data_oe),
		.i_dev_data_in  (i_dev_data_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Event decode for the sequencer
	wire       poll_busy   = (cur_op.kind == dca_pkg::OP_POLL) & acc_rdata[`CM_BUSY_BIT];
	wire       tmo_seen    = acc_rdata[`IRQ_TIMEOUT_BIT];
	wire [2:0] new_who     = acc_rdata[2:0];
	wire       who_evt     = (state_reg == dca_pkg::S_IRQ_WHO) & acc_done;
	wire       new_hit     = (err_cnt_reg[new_who] == `ERR_LIMIT - 2'h1);
	wire [7:0] who_bit     = 8'h01 << who_reg;

	// Main sequencer
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg     <= dca_pkg::S_IDLE;
			step_reg      <= 7'h00;
			live_mask_reg <= 8'h00;
			who_reg       <= 3'h0;
			hit_reg       <= 1'b0;
			tmo_cnt_reg   <= 8'h00;
			acc_go_reg    <= 1'b0;
			acc_write_reg <= 1'b0;
			acc_addr_reg  <= 8'h00;
			acc_wdata_reg <= 8'h00;
		end else begin
			acc_go_reg <= 1'b0;
			unique case (state_reg)
				dca_pkg::S_IDLE, dca_pkg::S_RUN: begin
					if (start_cmd) begin
						step_reg      <= 7'h00;
						live_mask_reg <= cfg_mask_reg;
						state_reg     <= dca_pkg::S_ISSUE;
					end else if ((state_reg == dca_pkg::S_RUN) & irq_sync) begin
						acc_go_reg    <= 1'b1;
						acc_write_reg <= 1'b0;
						acc_addr_reg  <= `DEV_IRQ_STAT;
						state_reg     <= dca_pkg::S_IRQ_STAT;
					end
				end
				dca_pkg::S_ISSUE: begin
					acc_go_reg    <= 1'b1;
					acc_write_reg <= (cur_op.kind == dca_pkg::OP_WRITE);
					acc_addr_reg  <= cur_op.addr;
					acc_wdata_reg <= cur_op.data;
					state_reg     <= dca_pkg::S_WAIT;
				end
				dca_pkg::S_WAIT: begin
					if (acc_done) begin
						if (poll_busy)
							state_reg <= dca_pkg::S_ISSUE;
						else if (step_reg == `STEP_LAST)
							state_reg <= dca_pkg::S_RUN;
						else begin
							step_reg  <= step_reg + 7'h01;
							state_reg <= dca_pkg::S_ISSUE;
						end
					end
				end
				dca_pkg::S_IRQ_STAT: begin
					if (acc_done & tmo_seen) begin
						acc_go_reg    <= 1'b1;
						acc_write_reg <= 1'b0;
						acc_addr_reg  <= `DEV_ARB_VIEW;
						state_reg     <= dca_pkg::S_IRQ_WHO;
					end else if (acc_done)
						state_reg <= dca_pkg::S_RUN;
				end
				dca_pkg::S_IRQ_WHO: begin
					if (acc_done) begin
						who_reg       <= new_who;
						hit_reg       <= new_hit;
						tmo_cnt_reg   <= tmo_cnt_reg + 8'h01;
						acc_go_reg    <= 1'b1;
						acc_write_reg <= 1'b1;
						acc_addr_reg  <= `DEV_HDLC_CMD;
						acc_wdata_reg <= `HDLC_RX_RESET;
						state_reg     <= dca_pkg::S_IRQ_RRES;
					end
				end
				dca_pkg::S_IRQ_RRES: begin
					if (acc_done & hit_reg) begin
						live_mask_reg <= live_mask_reg & ~who_bit;
						acc_go_reg    <= 1'b1;
						acc_write_reg <= 1'b1;
						acc_addr_reg  <= `DEV_DCH_EN;
						acc_wdata_reg <= live_mask_reg & ~who_bit;
						state_reg     <= dca_pkg::S_IRQ_MASK;
					end else if (acc_done)
						state_reg <= dca_pkg::S_RUN;
				end
				dca_pkg::S_IRQ_MASK: begin
					if (acc_done)
						state_reg <= dca_pkg::S_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-subscriber timeout counters, cleared by start
	genvar i;
	generate
		for (i = 0; i < `SUB_COUNT; i++) begin : g_err
			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n)
					err_cnt_reg[i] <= 2'h0;
				else if (start_cmd)
					err_cnt_reg[i] <= 2'h0;
				else if (who_evt & (new_who == 3'(i)) & (err_cnt_reg[i] != `ERR_LIMIT))
					err_cnt_reg[i] <= err_cnt_reg[i] + 2'h1;
			end
		end
	endgenerate

endmodule

// [src/dca_pkg.sv]
// Types for the D-channel arbiter host controller.
// Assumes dca_defines.svh supplies all numeric constants.
package dca_pkg;

	// Kind of device bus step
	typedef enum logic [1:0] {
		OP_WRITE = 2'b01,
		OP_POLL  = 2'b10
	} op_kind_t;

	// One device bus step
	typedef struct packed {
		op_kind_t    kind;
		logic [7:0]  addr;
		logic [7:0]  data;
	} op_t;

	// Main controller states
	typedef enum logic [7:0] {
		S_IDLE     = 8'b0000_0001,
		S_ISSUE    = 8'b0000_0010,
		S_WAIT     = 8'b0000_0100,
		S_RUN      = 8'b0000_1000,
		S_IRQ_STAT = 8'b0001_0000,
		S_IRQ_WHO  = 8'b0010_0000,
		S_IRQ_RRES = 8'b0100_0000,
		S_IRQ_MASK = 8'b1000_0000
	} ctl_state_t;

	// Device bus access states
	typedef enum logic [3:0] {
		A_IDLE   = 4'b0001,
		A_SETUP  = 4'b0010,
		A_STROBE = 4'b0100,
		A_HOLD   = 4'b1000
	} acc_state_t;

endpackage

// [src/dev_access.sv]
// Device bus access: one read or write per request, fixed strobe.
// Assumes the device drives read data while read strobe is low.
`timescale 1ns/1ps
`include "dca_defines.svh"
module dev_access (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	// Request side
	input  wire logic       i_go,
	input  wire logic       i_write,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic            o_done,
	output logic      [7:0] o_rdata,
	// Device pins
	output logic            o_dev_cs_n,
	output logic            o_dev_wr_n,
	output logic            o_dev_rd_n,
	output logic      [7:0] o_dev_addr,
	output logic      [7:0] o_dev_data_out,
	output logic            o_dev_data_oe,
	input  wire logic [7:0] i_dev_data_in
);

	dca_pkg::acc_state_t state_reg;
	logic [3:0]          cnt_reg;
	logic                write_reg;
	logic [7:0]          rdata_reg;
	logic [7:0]          addr_reg;
	logic [7:0]          wdata_reg;
	logic [7:0]          data_sync;

	localparam logic [3:0] STROBE_LAST = 4'(`DEV_STROBE_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Read data enters through two flip-flops
	sync2 #(.W(8)) u_data_sync (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_async   (i_dev_data_in),
		.o_sync    (data_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Access sequence: setup, strobe, hold
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= dca_pkg::A_IDLE;
			cnt_reg   <= 4'h0;
			write_reg <= 1'b0;
			addr_reg  <= 8'h00;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				dca_pkg::A_IDLE: begin
					if (i_go) begin
						write_reg <= i_write;
						addr_reg  <= i_addr;
						wdata_reg <= i_wdata;
						state_reg <= dca_pkg::A_SETUP;
					end
				end
				dca_pkg::A_SETUP: begin
					cnt_reg   <= 4'h0;
					state_reg <= dca_pkg::A_STROBE;
				end
				dca_pkg::A_STROBE: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == STROBE_LAST) begin
						rdata_reg <= data_sync;
						state_reg <= dca_pkg::A_HOLD;
					end
				end
				dca_pkg::A_HOLD: state_reg <= dca_pkg::A_IDLE;
			endcase
		end
	end

	// Pin decode from state
	wire in_cycle  = (state_reg != dca_pkg::A_IDLE);
	wire strobing  = (state_reg == dca_pkg::A_STROBE);
	assign o_dev_cs_n     = ~in_cycle;
	assign o_dev_wr_n     = ~(strobing & write_reg);
	assign o_dev_rd_n     = ~(strobing & ~write_reg);
	assign o_dev_addr     = addr_reg;
	assign o_dev_data_out = wdata_reg;
	assign o_dev_data_oe  = in_cycle & write_reg;
	assign o_done         = (state_reg == dca_pkg::A_HOLD);
	assign o_rdata        = rdata_reg;

endmodule

// [src/sync2.sv]
// Two flip-flop synchroniser, one per bit.
// Assumes inputs come from outside the i_clock domain.
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_reset_n,
	// Data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// Two stages per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= i_async[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign o_sync = sync_reg;

endmodule
